// ### uart_lsr_pkg.sv
// Shared constants for the line status flag block
package uart_lsr_pkg;
   // Register bus geometry
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   // Register offsets
   localparam logic [2:0] REG_DATA = 3'h0;
   localparam logic [2:0] REG_EV_MASK = 3'h1;
   localparam logic [2:0] REG_EV_STATUS = 3'h2;
   localparam logic [2:0] REG_CONFIG = 3'h3;
   localparam logic [2:0] REG_LINE_STATUS = 3'h4;
   // Line status bit positions
   localparam int LS_READY = 0;
   localparam int LS_OVERRUN = 1;
   localparam int LS_PARITY = 2;
   localparam int LS_FRAMING = 3;
   localparam int LS_BREAK = 4;
   localparam int LS_HOLD_EMPTY = 5;
   localparam int LS_TX_EMPTY = 6;
   localparam int LS_FIFO_ERR = 7;
   // Event status and mask bit positions
   localparam int EV_RX_READY = 0;
   localparam int EV_LINE_ERR = 1;
   localparam int EV_HOLD_EMPTY = 2;
   localparam int EV_W = 3;
   // Configuration fields and reset values
   localparam int CFG_FIFO_EN = 0;
   localparam int CFG_FRAME_LSB = 4;
   localparam int CFG_FRAME_W = 4;
   localparam logic [7:0] CONFIG_RESET = 8'hA0;
   localparam logic [EV_W-1:0] EV_MASK_RESET = 3'h0;
   // FIFO geometry
   localparam int FIFO_DEPTH = 16;
   localparam int PTR_W = 4;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] DEPTH_FIFO = 5'h10;
   localparam logic [CNT_W-1:0] DEPTH_PLAIN = 5'h01;
   localparam logic [7:0] BREAK_CHAR = 8'h00;
endpackage : uart_lsr_pkg

// ### rx_error_fifo.sv
// Receive FIFO holding each character with its own error flags
`timescale 1ns/1ps
`default_nettype none
module rx_error_fifo (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   // Write side
   input wire logic push_in,
   input wire logic [7:0] data_in,
   input wire logic parity_err_in,
   input wire logic framing_err_in,
   input wire logic break_in,
   input wire logic [uart_lsr_pkg::CNT_W-1:0] limit_in,
   // Read side
   input wire logic pop_in,
   output logic [7:0] head_data_out,
   output logic [2:0] head_flags_out,
   output logic [uart_lsr_pkg::CNT_W-1:0] count_out,
   output logic full_out,
   output logic err_any_out
);
   import uart_lsr_pkg::*;

   logic [10:0] mem [FIFO_DEPTH];
   logic [PTR_W-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [CNT_W-1:0] count, next_count, err_count, next_err_count;
   logic do_push, do_pop, push_err, head_err;

   assign full_out = (count >= limit_in);
   assign do_push = push_in && !full_out;
   assign do_pop = pop_in && (count != 5'h00);
   assign push_err = parity_err_in | framing_err_in | break_in;
   assign head_err = |mem[rd_ptr][10:8];

   always_comb begin
      next_wr_ptr = wr_ptr + PTR_W'(do_push);
      next_rd_ptr = rd_ptr + PTR_W'(do_pop);
      next_count = count + CNT_W'(do_push) - CNT_W'(do_pop);
      // Counts queued characters that still carry an error
      next_err_count = err_count + CNT_W'(do_push && push_err)
                       - CNT_W'(do_pop && head_err);
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wr_ptr <= 4'h0;
         rd_ptr <= 4'h0;
         count <= 5'h00;
         err_count <= 5'h00;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         err_count <= next_err_count;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (do_push) begin
         mem[wr_ptr] <= {break_in, framing_err_in, parity_err_in, data_in};
      end
   end

   assign head_data_out = (count != 5'h00) ? mem[rd_ptr][7:0] : 8'h00;
   assign head_flags_out = (count != 5'h00) ? mem[rd_ptr][10:8] : 3'h0;
   assign count_out = count;
   assign err_any_out = (err_count != 5'h00);
endmodule : rx_error_fifo
`default_nettype wire

// ### break_detector.sv
// Detects the receive line held low for a whole frame, once per break
`timescale 1ns/1ps
`default_nettype none
module break_detector (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   // Line and timing
   input wire logic rx_line_in,
   input wire logic bit_tick_in,
   input wire logic [uart_lsr_pkg::CFG_FRAME_W-1:0] frame_bits_in,
   // Result
   output logic break_pulse_out
);
   import uart_lsr_pkg::*;

   logic [CFG_FRAME_W-1:0] low_bits, next_low_bits;
   logic fired, next_fired, next_pulse;

   always_comb begin
      next_low_bits = low_bits;
      next_fired = fired;
      next_pulse = 1'b0;
      if (rx_line_in) begin
         next_low_bits = 4'h0;
         next_fired = 1'b0;
      end else if (bit_tick_in && !fired) begin
         next_low_bits = low_bits + 4'h1;
         if (next_low_bits >= frame_bits_in) begin
            // Only one report until the line returns high
            next_fired = 1'b1;
            next_pulse = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         low_bits <= 4'h0;
         fired <= 1'b0;
         break_pulse_out <= 1'b0;
      end else begin
         low_bits <= next_low_bits;
         fired <= next_fired;
         break_pulse_out <= next_pulse;
      end
   end
endmodule : break_detector
`default_nettype wire

// ### uart_line_status_flags.sv
// Line status flags, transmit holding stage and receive error FIFO
//
// Functional notes
// - FIFO mode: error summary sets while any queued character carries an error.
// - Summary clears once no queued character carries an error.
// - Plain mode: transmitter empty is 1 when holding and shift are empty.
// - Transmitter empty is 0 while holding stage or shift holds a character.
// - FIFO mode: transmitter empty is 1 when FIFO and shift are empty.
// - Plain mode: holding empty sets when the character moves to shift.
// - Plain mode: holding empty clears on the CPU write to holding.
// - FIFO mode: holding empty tracks transmit FIFO being empty.
// - Interrupt requested while holding empty and its enable are set.
// - Break flag sets when the line stays low a whole frame.
// - FIFO mode: one break character queued per break condition.
// - Framing flag sets when the stop bit is not valid.
// - Framing flag reported for the head character, stored per character.
// - Error summary, break and framing flags are 0 after reset.
// - Parity flag reported for the head character on a parity failure.
// - Full FIFO: new character sets overrun and is not stored.
// - Ready flag set while a received character is held.
`timescale 1ns/1ps
`default_nettype none
module uart_line_status_flags (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   // Register bus
   input wire logic [uart_lsr_pkg::ADDR_W-1:0] addr_in,
   input wire logic [uart_lsr_pkg::DATA_W-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [uart_lsr_pkg::DATA_W-1:0] rdata_out,
   // Serial receive pin and bit timing
   input wire logic rx_serial_in,
   input wire logic bit_tick_in,
   // Receiver character strobe
   input wire logic rx_char_valid_in,
   input wire logic [7:0] rx_char_in,
   input wire logic rx_parity_ok_in,
   input wire logic rx_stop_ok_in,
   // Transmitter side
   output logic tx_valid_out,
   output logic [7:0] tx_data_out,
   input wire logic tx_take_in,
   input wire logic tx_shift_busy_in,
   // Interrupt
   output logic irq_out
);
   import uart_lsr_pkg::*;

   // Pin synchroniser
   logic rx_meta, rx_line;

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rx_meta <= 1'b1;
         rx_line <= 1'b1;
      end else begin
         rx_meta <= rx_serial_in;
         rx_line <= rx_meta;
      end
   end

   // Bus decode
   logic wr_data, wr_mask, wr_status, wr_config, rd_data, rd_line_status;

   assign wr_data = wr_in && (addr_in == REG_DATA);
   assign wr_mask = wr_in && (addr_in == REG_EV_MASK);
   assign wr_status = wr_in && (addr_in == REG_EV_STATUS);
   assign wr_config = wr_in && (addr_in == REG_CONFIG);
   assign rd_data = rd_in && (addr_in == REG_DATA);
   assign rd_line_status = rd_in && (addr_in == REG_LINE_STATUS);

   // Configuration and mask
   logic [7:0] line_config, next_line_config;
   logic [EV_W-1:0] ev_mask, next_ev_mask;
   logic fifo_en;
   logic [CFG_FRAME_W-1:0] frame_bits;
   logic [CNT_W-1:0] depth_limit;

   always_comb begin
      next_line_config = wr_config ? wdata_in : line_config;
      next_ev_mask = wr_mask ? wdata_in[EV_W-1:0] : ev_mask;
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         line_config <= CONFIG_RESET;
         ev_mask <= EV_MASK_RESET;
      end else begin
         line_config <= next_line_config;
         ev_mask <= next_ev_mask;
      end
   end

   assign fifo_en = line_config[CFG_FIFO_EN];
   assign frame_bits = line_config[CFG_FRAME_LSB +: CFG_FRAME_W];
   // Plain mode is a FIFO of one character
   assign depth_limit = fifo_en ? DEPTH_FIFO : DEPTH_PLAIN;

   // Transmit holding stage or FIFO
   logic [7:0] tx_mem [FIFO_DEPTH];
   logic [PTR_W-1:0] tx_wr_ptr, tx_rd_ptr, next_tx_wr_ptr, next_tx_rd_ptr;
   logic [CNT_W-1:0] tx_count, next_tx_count;
   logic tx_push, tx_pop, holding_empty, tx_fully_empty;

   assign tx_push = wr_data && (tx_count < depth_limit);
   assign tx_pop = tx_take_in && (tx_count != 5'h00);

   always_comb begin
      next_tx_wr_ptr = tx_wr_ptr + PTR_W'(tx_push);
      next_tx_rd_ptr = tx_rd_ptr + PTR_W'(tx_pop);
      next_tx_count = tx_count + CNT_W'(tx_push) - CNT_W'(tx_pop);
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tx_wr_ptr <= 4'h0;
         tx_rd_ptr <= 4'h0;
         tx_count <= 5'h00;
      end else begin
         tx_wr_ptr <= next_tx_wr_ptr;
         tx_rd_ptr <= next_tx_rd_ptr;
         tx_count <= next_tx_count;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (tx_push) begin
         tx_mem[tx_wr_ptr] <= wdata_in;
      end
   end

   assign tx_valid_out = (tx_count != 5'h00);
   assign tx_data_out = tx_mem[tx_rd_ptr];
   assign holding_empty = (tx_count == 5'h00);
   // Holding stage or FIFO and shift register both idle
   assign tx_fully_empty = holding_empty
                           && !tx_shift_busy_in;

   // Break detection
   logic brk_pulse;

   break_detector u_break (
      .clk_sys_in(clk_sys_in),
      .rstn_in(rstn_in),
      .rx_line_in(rx_line),
      .bit_tick_in(bit_tick_in),
      .frame_bits_in(frame_bits),
      .break_pulse_out(brk_pulse)
   );

   // Receive FIFO
   logic rx_push, rx_pop, rx_full, rx_err_any;
   logic [7:0] rx_push_data, rx_head_data;
   logic rx_push_pe, rx_push_fe, rx_push_bi;
   logic [2:0] rx_head_flags;
   logic [CNT_W-1:0] rx_count;

   always_comb begin
      rx_push = brk_pulse || rx_char_valid_in;
      rx_push_data = rx_char_in;
      rx_push_pe = !rx_parity_ok_in;
      rx_push_fe = !rx_stop_ok_in;
      rx_push_bi = 1'b0;
      if (brk_pulse) begin
         // A single break character stands for the whole break
         rx_push_data = BREAK_CHAR;
         rx_push_pe = 1'b0;
         rx_push_fe = 1'b1;
         rx_push_bi = 1'b1;
      end
   end

   assign rx_pop = rd_data;

   rx_error_fifo u_rx_fifo (
      .clk_sys_in(clk_sys_in),
      .rstn_in(rstn_in),
      .push_in(rx_push),
      .data_in(rx_push_data),
      .parity_err_in(rx_push_pe),
      .framing_err_in(rx_push_fe),
      .break_in(rx_push_bi),
      .limit_in(depth_limit),
      .pop_in(rx_pop),
      .head_data_out(rx_head_data),
      .head_flags_out(rx_head_flags),
      .count_out(rx_count),
      .full_out(rx_full),
      .err_any_out(rx_err_any)
   );

   // Line status flags
   logic overrun, next_overrun, head_seen, next_head_seen;
   logic [7:0] line_status;

   always_comb begin
      next_overrun = overrun;
      next_head_seen = head_seen;
      if (rd_line_status) begin
         next_overrun = 1'b0;
      end
      // Only a character already held can be hidden by a status read
      if (rd_line_status && (rx_count != 5'h00)) begin
         next_head_seen = 1'b1;
      end
      if (rx_pop) begin
         next_head_seen = 1'b0;
      end
      // A new overrun wins over a clearing read
      if (rx_push && rx_full) begin
         next_overrun = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         overrun <= 1'b0;
         head_seen <= 1'b0;
      end else begin
         overrun <= next_overrun;
         head_seen <= next_head_seen;
      end
   end

   always_comb begin
      line_status = 8'h00;
      line_status[LS_READY] = (rx_count != 5'h00);
      line_status[LS_OVERRUN] = overrun;
      line_status[LS_PARITY] = rx_head_flags[0] && !head_seen;
      line_status[LS_FRAMING] = rx_head_flags[1] && !head_seen;
      line_status[LS_BREAK] = rx_head_flags[2] && !head_seen;
      line_status[LS_HOLD_EMPTY] = holding_empty;
      line_status[LS_TX_EMPTY] = tx_fully_empty;
      line_status[LS_FIFO_ERR] = fifo_en
                                 && rx_err_any;
   end

   // Event status and interrupt
   logic [EV_W-1:0] ev_status, next_ev_status, ev_set;

   always_comb begin
      ev_set = '0;
      ev_set[EV_RX_READY] = rx_push && !rx_full;
      ev_set[EV_LINE_ERR] = (rx_push && rx_full) || brk_pulse ||
                            (rx_char_valid_in && !(rx_parity_ok_in &&
                                                   rx_stop_ok_in));
      ev_set[EV_HOLD_EMPTY] = holding_empty;
      next_ev_status = ev_status;
      if (wr_status) begin
         next_ev_status = ev_status & ~wdata_in[EV_W-1:0];
      end
      // Set wins over a simultaneous clear
      next_ev_status = next_ev_status | ev_set;
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ev_status <= '0;
      end else begin
         ev_status <= next_ev_status;
      end
   end

   assign irq_out = |(ev_status & ev_mask);

   // Read data, valid in the cycle after the read strobe
   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = 8'h00;
      if (rd_in) begin
         unique case (addr_in)
            REG_DATA: next_rdata = rx_head_data;
            REG_EV_MASK: next_rdata = {5'h00, ev_mask};
            REG_EV_STATUS: next_rdata = {5'h00, ev_status};
            REG_CONFIG: next_rdata = line_config;
            REG_LINE_STATUS: next_rdata = line_status;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rdata_out <= 8'h00;
      end else begin
         rdata_out <= next_rdata;
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);

   a_summary_plain: assert property (
      !fifo_en |-> !line_status[LS_FIFO_ERR])
      else $error("error summary set in plain mode");
   a_summary_clear: assert property (
      (rx_count == 5'h00) |-> !line_status[LS_FIFO_ERR])
      else $error("error summary set with empty receive FIFO");
   a_summary_set: assert property (
      fifo_en && rx_char_valid_in && !(rx_parity_ok_in && rx_stop_ok_in)
      && !rx_full && !wr_config |=> line_status[LS_FIFO_ERR])
      else $error("error summary not set by a queued error");
   a_hold_write: assert property (
      tx_push |=> !line_status[LS_HOLD_EMPTY])
      else $error("holding empty not cleared by write");
   a_hold_move: assert property (
      tx_pop && !tx_push && tx_count == 5'h01
      |=> line_status[LS_HOLD_EMPTY])
      else $error("holding empty not set after move to shift");
   a_tx_busy: assert property (
      tx_shift_busy_in |-> !line_status[LS_TX_EMPTY])
      else $error("transmitter empty while shift busy");
   a_tx_idle: assert property (
      holding_empty && !tx_shift_busy_in |-> line_status[LS_TX_EMPTY])
      else $error("transmitter empty not set while idle");
   a_break_queue: assert property (
      brk_pulse && !rx_full && !rx_pop
      |=> rx_count == $past(rx_count) + 5'h01)
      else $error("break character not queued");
   a_break_once: assert property (
      brk_pulse |=> !brk_pulse ##1 !brk_pulse)
      else $error("break reported twice in a row");
   a_break_flag: assert property (
      brk_pulse && rx_count == 5'h00 |=> line_status[LS_BREAK])
      else $error("break flag not set after break");
   a_overrun_set: assert property (
      rx_push && rx_full |=> line_status[LS_OVERRUN]
      && rx_count == $past(rx_count) - CNT_W'($past(rx_pop)))
      else $error("overrun not flagged or FIFO changed");
   a_frame_head: assert property (
      rx_char_valid_in && !rx_stop_ok_in && !brk_pulse
      && rx_count == 5'h00 && !rd_in
      |=> line_status[LS_FRAMING])
      else $error("framing error not reported at head");
   a_read_clear: assert property (
      rd_line_status && rx_count != 5'h00 |=> !line_status[LS_PARITY]
      && !line_status[LS_FRAMING] && !line_status[LS_BREAK])
      else $error("error flags not hidden after status read");
   a_ready_flag: assert property (
      rx_push && !rx_full |=> line_status[LS_READY])
      else $error("ready flag not set after receive");
   a_hold_irq: assert property (
      holding_empty && ev_mask[EV_HOLD_EMPTY] && !wr_mask
      |=> irq_out)
      else $error("holding empty interrupt missing");

   c_break: cover property (brk_pulse ##1 line_status[LS_BREAK]);
   c_overrun: cover property (rx_push && rx_full);
   c_summary: cover property (fifo_en && line_status[LS_FIFO_ERR]);
   c_irq: cover property ($rose(irq_out));
   c_framing: cover property (rx_char_valid_in && !rx_stop_ok_in);
endmodule : uart_line_status_flags
`default_nettype wire

// ### tx_sink_model.sv
// Behavioural transmitter that drains the holding stage of the block
`timescale 1ns/1ps
`default_nettype none
module tx_sink_model #(
   parameter int SHIFT_CYC = 20
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   // Holding stage side
   input wire logic tx_valid_in,
   input wire logic [7:0] tx_data_in,
   input wire logic stall_in,
   output logic tx_take_out,
   output logic tx_shift_busy_out,
   // Last character moved into the shift register
   output logic [7:0] sent_out
);
   int count;
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tx_take_out <= 1'b0;
         tx_shift_busy_out <= 1'b0;
         count <= 0;
         sent_out <= 8'h00;
      end else begin
         // Take only when idle, so a stall keeps the holding stage full
         tx_take_out <= tx_valid_in && !stall_in && !tx_shift_busy_out &&
            !tx_take_out;
         if (tx_take_out) begin
            sent_out <= tx_data_in;
            tx_shift_busy_out <= 1'b1;
            count <= SHIFT_CYC;
         end else if (count > 0) begin
            count <= count - 1;
         end else begin
            tx_shift_busy_out <= 1'b0;
         end
      end
   end
endmodule : tx_sink_model
`default_nettype wire

// ### tb_top.sv
// Self-checking testbench for the line status flag block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import uart_lsr_pkg::*;
   logic clk_sys_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [2:0] addr_in = 3'h0;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic rx_serial_in = 1'b1;
   logic bit_tick_in = 1'b0;
   logic rx_char_valid_in = 1'b0;
   logic [7:0] rx_char_in = 8'h00;
   logic rx_parity_ok_in = 1'b1;
   logic rx_stop_ok_in = 1'b1;
   logic stall = 1'b0;
   logic [7:0] rdata_out, tx_data_out, sent, d, x;
   logic tx_valid_out, tx_take_in, tx_shift_busy_in, irq_out;
   logic [7:0] q [6];
   int k;
   int mismatches = 0;
   int comparisons = 0;
   int seed = 32'h31E2;

   uart_line_status_flags uart_line_status_flags_i (.clk_sys_in, .rstn_in,
      .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .rx_serial_in,
      .bit_tick_in, .rx_char_valid_in, .rx_char_in, .rx_parity_ok_in,
      .rx_stop_ok_in, .tx_valid_out, .tx_data_out, .tx_take_in,
      .tx_shift_busy_in, .irq_out);
   tx_sink_model tx_sink_model_i (.clk_sys_in, .rstn_in,
      .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out),
      .stall_in(stall), .tx_take_out(tx_take_in),
      .tx_shift_busy_out(tx_shift_busy_in), .sent_out(sent));

   always #50 clk_sys_in = ~clk_sys_in;

   task automatic report_and_stop;
      if (mismatches == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk

   function automatic logic [7:0] ls(input logic rdy, ovr, par, frm, brk,
                                     he, te, fe);
      return {fe, te, he, brk, frm, par, ovr, rdy};
   endfunction : ls

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk_sys_in);
      addr_in <= a;
      wdata_in <= v;
      wr_in <= 1'b1;
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge clk_sys_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      // Read data stand in the cycle after the strobe
      @(posedge clk_sys_in);
      v = rdata_out;
   endtask : rd

   task automatic rxc(input logic [7:0] c, input logic p, input logic s);
      @(posedge clk_sys_in);
      rx_char_valid_in <= 1'b1;
      rx_char_in <= c;
      rx_parity_ok_in <= p;
      rx_stop_ok_in <= s;
      @(posedge clk_sys_in);
      rx_char_valid_in <= 1'b0;
   endtask : rxc

   task automatic tick;
      @(posedge clk_sys_in);
      bit_tick_in <= 1'b1;
      @(posedge clk_sys_in);
      bit_tick_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask : tick

   task automatic wait_ls(input int b, input logic v);
      for (int i = 0; i < 200; i++) begin
         rd(REG_LINE_STATUS, d);
         if (d[b] === v) return;
      end
      mismatches++;
      report_and_stop();
   endtask : wait_ls

   initial begin
      repeat (50000) @(posedge clk_sys_in);
      mismatches++;
      report_and_stop();
   end

   initial begin
      repeat (4) @(posedge clk_sys_in);
      rstn_in <= 1'b1;
      // Reset values and an unmapped address
      rd(REG_LINE_STATUS, d);
      chk(d, ls(0, 0, 0, 0, 0, 1, 1, 0));
      rd(REG_CONFIG, d);
      chk(d, CONFIG_RESET);
      rd(REG_EV_MASK, d);
      chk(d, 8'h00);
      wr(3'h6, 8'hFF);
      rd(3'h6, d);
      chk(d, 8'h00);
      // Plain mode transmit with the holding stage held full by a stall
      stall <= 1'b1;
      x = 8'($random(seed));
      wr(REG_DATA, x);
      rd(REG_LINE_STATUS, d);
      chk(d & 8'h60, 8'h00);
      chk({7'h0, tx_valid_out}, 8'h01);
      chk(tx_data_out, x);
      stall <= 1'b0;
      wait_ls(LS_HOLD_EMPTY, 1'b1);
      chk(d & 8'h60, 8'h20);
      wait_ls(LS_TX_EMPTY, 1'b1);
      chk(sent, x);
      // Holding empty interrupt, masked and cleared
      wr(REG_EV_MASK, 8'h04);
      @(posedge clk_sys_in);
      chk({7'h0, irq_out}, 8'h01);
      stall <= 1'b1;
      wr(REG_DATA, 8'($random(seed)));
      wr(REG_EV_STATUS, 8'h04);
      @(posedge clk_sys_in);
      chk({7'h0, irq_out}, 8'h00);
      stall <= 1'b0;
      wait_ls(LS_TX_EMPTY, 1'b1);
      chk({7'h0, irq_out}, 8'h01);
      wr(REG_EV_MASK, 8'h00);
      @(posedge clk_sys_in);
      chk({7'h0, irq_out}, 8'h00);
      // Plain mode receive: framing, overrun, parity, read clear
      rxc(8'h5A, 1'b1, 1'b0);
      rd(REG_LINE_STATUS, d);
      chk(d, ls(1, 0, 0, 1, 0, 1, 1, 0));
      rxc(8'hC3, 1'b0, 1'b1);
      rd(REG_LINE_STATUS, d);
      chk(d, ls(1, 1, 0, 0, 0, 1, 1, 0));
      rd(REG_LINE_STATUS, d);
      chk(d, ls(1, 0, 0, 0, 0, 1, 1, 0));
      rd(REG_DATA, d);
      chk(d, 8'h5A);
      x = 8'($random(seed));
      rxc(x, 1'b0, 1'b1);
      rd(REG_LINE_STATUS, d);
      chk(d, ls(1, 0, 1, 0, 0, 1, 1, 0));
      rd(REG_DATA, d);
      chk(d, x);
      rd(REG_LINE_STATUS, d);
      chk(d, ls(0, 0, 0, 0, 0, 1, 1, 0));
      rd(REG_EV_STATUS, d);
      chk(d, 8'h07);
      wr(REG_EV_STATUS, 8'h03);
      rd(REG_EV_STATUS, d);
      chk(d, 8'h04);
      // FIFO mode: one framing error at a random depth
      wr(REG_CONFIG, 8'hA1);
      k = {$random(seed)} % 6;
      for (int i = 0; i < 6; i++) begin
         q[i] = 8'($random(seed));
         rxc(q[i], 1'b1, i != k);
      end
      for (int i = 0; i < 6; i++) begin
         rd(REG_LINE_STATUS, d);
         chk(d, ls(1, 0, 0, i == k, 0, 1, 1, k >= i));
         rd(REG_DATA, d);
         chk(d, q[i]);
      end
      rd(REG_LINE_STATUS, d);
      chk(d, ls(0, 0, 0, 0, 0, 1, 1, 0));
      // Long break queues a single break character
      rx_serial_in <= 1'b0;
      repeat (25) tick();
      rx_serial_in <= 1'b1;
      repeat (3) tick();
      rd(REG_LINE_STATUS, d);
      chk(d, ls(1, 0, 0, 1, 1, 1, 1, 1));
      rd(REG_DATA, d);
      chk(d, BREAK_CHAR);
      rd(REG_LINE_STATUS, d);
      chk(d, ls(0, 0, 0, 0, 0, 1, 1, 0));
      // FIFO mode transmit of three bytes
      stall <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         wr(REG_DATA, q[i]);
      end
      rd(REG_LINE_STATUS, d);
      chk(d & 8'h60, 8'h00);
      stall <= 1'b0;
      wait_ls(LS_TX_EMPTY, 1'b1);
      chk(d & 8'h60, 8'h60);
      chk(sent, q[2]);
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
